// ---- rtl/uart_regs.sv ----
/*
  Register side of the asynchronous serial port: holding registers, ready and
  overrun handshakes, sticky status, interrupt enables and optional divisor
  and end-of-packet registers. Received characters pass a 16-word FIFO on
  their way into the receive holding register.
  Assumes an external shifter that presents finished characters as one-cycle
  strobes, accepts a transmit character on a load handshake and reports busy.
  CTS_N and RXD come from pins and are synchronised here.
*/
// Overview of operation
// - Finished character loads receive holding, sets ready
// - Reading receive holding clears receive ready
// - Load while ready overwrites and sets overrun
// - Writes to receive holding do nothing
// - Writing transmit holding clears transmit ready
// - Transmit ready sets when shifter takes character
// - Write while not ready sets transmit overrun
// - Status reads change no bits
// - Writing zero to status clears sticky flags
// - Bad parity sets sticky flag when enabled
// - Bad stop bit sets sticky framing flag
// - Line low past character time sets break
// - Transmit empty is zero while shifting
// - Fault summary is OR of five errors
// - Any clear-to-send transition sets change flag
// - Clear-to-send bit shows inverted sampled input
// - End character through receive holding sets flag
// - Receive holding and end character bits above data width read zero
// - Absent optional registers ignore writes, read undefined
// - Interrupt when flag and matching enable set
// - Reset clears all interrupt enables
module uart_regs
  import uart_regs_pkg::*;
#(
  parameter int DATA_W       = 8,
  parameter bit HAS_PARITY   = 1'b1,
  parameter bit HAS_FLOW     = 1'b1,
  parameter bit HAS_DIVISOR  = 1'b1,
  parameter bit HAS_EOP      = 1'b1,
  parameter int CHAR_BITS    = 11
)
(
  // Clock and reset
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  // Register port
  input  wire logic        CHIP_SELECT,
  input  wire logic        READ_EN,
  input  wire logic        WRITE_EN,
  input  wire logic [2:0]  ADDRESS,
  input  wire logic [15:0] WRITE_DATA,
  output logic      [15:0] READ_DATA,
  output logic             IRQ,
  // Serial pins
  input  wire logic        RXD,
  input  wire logic        CTS_N,
  output logic             RTS_N,
  output logic             TX_BREAK,
  // Receive shifter
  input  wire logic        RX_DONE,
  input  wire logic [15:0] RX_CHAR,
  input  wire logic        RX_PARITY_BAD,
  input  wire logic        RX_STOP_BAD,
  output logic             RX_FIFO_READY,
  // Transmit shifter
  input  wire logic        TX_BUSY,
  input  wire logic        TX_TAKE,
  output logic             TX_LOAD,
  output logic      [15:0] TX_CHAR,
  output logic      [15:0] BAUD_DIVISOR
);

  // ==========================================================================
  // Helpers
  function automatic logic [15:0] clip(input logic [15:0] v);
    clip = v & 16'((32'h1 << DATA_W) - 1);
  endfunction

  bus_req_t req;
  assign req.rd    = CHIP_SELECT && READ_EN;
  assign req.wr    = CHIP_SELECT && WRITE_EN;
  assign req.addr  = ADDRESS;
  assign req.wdata = WRITE_DATA;

  logic rd_rx, wr_tx, wr_st, wr_ctl, wr_div, wr_eop;
  assign rd_rx  = req.rd && req.addr == IDX_RX_HOLDING;
  assign wr_tx  = req.wr && req.addr == IDX_TX_HOLDING;
  assign wr_st  = req.wr && req.addr == IDX_LINE_STATUS;
  assign wr_ctl = req.wr && req.addr == IDX_IRQ_CONTROL;
  assign wr_div = req.wr && req.addr == IDX_BAUD_DIVISOR && HAS_DIVISOR;
  assign wr_eop = req.wr && req.addr == IDX_PACKET_END && HAS_EOP;

  // ==========================================================================
  // Pin synchronisers: change counts when stages two and three agree
  logic [2:0] rxd_s_r, cts_s_r;
  logic       cts_n_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      rxd_s_r <= 3'h7;
      cts_s_r <= 3'h7;
    end
    else
    begin
      rxd_s_r <= {rxd_s_r[1:0], RXD};
      cts_s_r <= {cts_s_r[1:0], CTS_N};
    end
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      cts_n_r <= 1'b1;
    else if (cts_s_r[1] == cts_s_r[2])
      cts_n_r <= cts_s_r[2];
  end

  logic cts_edge;
  assign cts_edge = (cts_s_r[1] == cts_s_r[2]) && (cts_s_r[2] != cts_n_r);

  // ==========================================================================
  // Receive FIFO and holding register
  rx_char_t fifo_in, fifo_out;
  logic     fifo_valid;
  logic     fifo_pop;

  assign fifo_in.parity_bad = RX_PARITY_BAD;
  assign fifo_in.stop_bad   = RX_STOP_BAD;
  assign fifo_in.data       = RX_CHAR;
  // Holding register takes a new character every cycle one is waiting,
  // so overrun still occurs while software lags.
  assign fifo_pop = fifo_valid;

  logic fifo_in_ready;

  char_fifo #(.WIDTH($bits(rx_char_t)), .DEPTH(FIFO_DEPTH)) u_fifo
  (
    .clk       (SYS_CLK),
    .rst       (RST),
    .in_valid  (RX_DONE),
    .in_ready  (fifo_in_ready),
    .in_data   (fifo_in),
    .out_valid (fifo_valid),
    .out_ready (1'b1),
    .out_data  (fifo_out)
  );

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      RX_FIFO_READY <= 1'b0;
    else
      RX_FIFO_READY <= fifo_in_ready;
  end

  logic [15:0] rx_hold_r;
  logic        rx_ready_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      rx_hold_r <= 16'h0000;
    else if (fifo_pop)
      rx_hold_r <= clip(fifo_out.data);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      rx_ready_r <= 1'b0;
    else if (fifo_pop)
      rx_ready_r <= 1'b1;
    else if (rd_rx)
      rx_ready_r <= 1'b0;
  end

  // ==========================================================================
  // Transmit holding register
  logic [15:0] tx_hold_r;
  logic        tx_ready_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      tx_hold_r <= 16'h0000;
    else if (wr_tx)
      tx_hold_r <= clip(req.wdata);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      tx_ready_r <= 1'b1;
    else if (wr_tx)
      tx_ready_r <= 1'b0;
    else if (TX_LOAD && TX_TAKE)
      tx_ready_r <= 1'b1;
  end

  // Held character is offered until the shifter, once idle, takes it
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      TX_LOAD <= 1'b0;
    else if (TX_LOAD && TX_TAKE)
      TX_LOAD <= 1'b0;
    else if (!tx_ready_r && !wr_tx)
      TX_LOAD <= 1'b1;
  end

  assign TX_CHAR = tx_hold_r;

  // ==========================================================================
  // Break detection on the synchronised line
  localparam int BRK_W = 24;
  logic [15:0]      div_r;
  logic [BRK_W-1:0] low_cnt_r;
  logic             brk_evt;
  logic [BRK_W-1:0] char_time;

  // One full character: bit count times (divisor + 1) clock cycles
  assign char_time = BRK_W'(CHAR_BITS) * (BRK_W'(div_r) + 1'b1);

  always_ff @(posedge SYS_CLK)
  begin
    if (RST || (rxd_s_r[1] && rxd_s_r[2]))
      low_cnt_r <= '0;
    else if (!rxd_s_r[1] && !rxd_s_r[2] && low_cnt_r <= char_time)
      low_cnt_r <= low_cnt_r + 1'b1;
  end

  assign brk_evt = !rxd_s_r[2] && (low_cnt_r == char_time);

  // ==========================================================================
  // Optional registers and control
  logic [15:0] eop_r;
  logic [12:0] ctl_r;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      div_r <= DIVISOR_RST;
    else if (wr_div)
      div_r <= req.wdata;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      eop_r <= PACKET_END_RST;
    else if (wr_eop)
      eop_r <= clip(req.wdata);
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      ctl_r <= CONTROL_RST[12:0];
    else if (wr_ctl)
    begin
      ctl_r <= req.wdata[12:0] & CONTROL_MASK;
      if (!HAS_FLOW)
        ctl_r[BIT_CTS] <= 1'b0;
    end
  end

  assign BAUD_DIVISOR = div_r;

  // ==========================================================================
  // Sticky status flags: set wins over clear
  logic pe_r, fe_r, brk_r, roe_r, toe_r, dcts_r, eop_flag_r;
  logic fault;

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      pe_r   <= 1'b0;
      fe_r   <= 1'b0;
      brk_r  <= 1'b0;
      roe_r  <= 1'b0;
      toe_r  <= 1'b0;
      dcts_r <= 1'b0;
    end
    else
    begin
      if (wr_st && req.wdata == 16'h0000)
      begin
        pe_r   <= 1'b0;
        fe_r   <= 1'b0;
        brk_r  <= 1'b0;
        roe_r  <= 1'b0;
        toe_r  <= 1'b0;
        dcts_r <= 1'b0;
      end
      if (fifo_pop && fifo_out.parity_bad && HAS_PARITY)
        pe_r <= 1'b1;
      if (fifo_pop && fifo_out.stop_bad)
        fe_r <= 1'b1;
      if (brk_evt)
        brk_r <= 1'b1;
      if (fifo_pop && rx_ready_r && !rd_rx)
        roe_r <= 1'b1;
      if (wr_tx && !tx_ready_r)
        toe_r <= 1'b1;
      if (cts_edge && HAS_FLOW)
        dcts_r <= 1'b1;
    end
  end

  // End-of-packet flag: cleared only by a zero write to status
  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      eop_flag_r <= 1'b0;
    else if (HAS_EOP && ((fifo_pop && clip(fifo_out.data) == eop_r) ||
                         (rd_rx && rx_hold_r == eop_r)))
      eop_flag_r <= 1'b1;
    else if (wr_st && req.wdata == 16'h0000)
      eop_flag_r <= 1'b0;
  end

  assign fault = pe_r | fe_r | brk_r | roe_r | toe_r;

  logic [15:0] status;
  always_comb
  begin
    status               = 16'h0000;
    status[BIT_PARITY]   = pe_r;
    status[BIT_STOP]     = fe_r;
    status[BIT_BREAK]    = brk_r;
    status[BIT_RX_OVR]   = roe_r;
    status[BIT_TX_OVR]   = toe_r;
    status[BIT_TX_EMPTY] = !TX_BUSY && !TX_LOAD;
    status[BIT_TX_READY] = tx_ready_r;
    status[BIT_RX_READY] = rx_ready_r;
    status[BIT_FAULT]    = fault;
    status[BIT_CTS_CHG]  = dcts_r;
    status[BIT_CTS]      = HAS_FLOW && !cts_n_r;
    status[BIT_EOP]      = eop_flag_r;
  end

  // ==========================================================================
  // Read data, interrupt and pin outputs, all registered
  logic [15:0] rd_mux;
  always_comb
  begin
    case (req.addr)
      IDX_RX_HOLDING:   rd_mux = rx_hold_r;
      IDX_LINE_STATUS:  rd_mux = status;
      IDX_IRQ_CONTROL:  rd_mux = {3'h0, ctl_r};
      IDX_BAUD_DIVISOR: rd_mux = HAS_DIVISOR ? div_r : UNDEF_READ;
      IDX_PACKET_END:   rd_mux = HAS_EOP ? eop_r : UNDEF_READ;
      default:          rd_mux = UNDEF_READ;
    endcase
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      READ_DATA <= 16'h0000;
    else if (req.rd)
      READ_DATA <= rd_mux;
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
      IRQ <= 1'b0;
    else
      IRQ <= |(status[12:0] & ctl_r & ~(13'h1 << BIT_TX_BREAK)
                & ~(13'h1 << BIT_CTS));
  end

  always_ff @(posedge SYS_CLK)
  begin
    if (RST)
    begin
      RTS_N    <= 1'b1;
      TX_BREAK <= 1'b0;
    end
    else
    begin
      RTS_N    <= !(HAS_FLOW && ctl_r[BIT_CTS]);
      TX_BREAK <= ctl_r[BIT_TX_BREAK];
    end
  end

endmodule

// ---- rtl/uart_regs_pkg.sv ----
/*
  Package for the serial port register block: register indices, status and
  control bit positions, reset values, FIFO depth and bus carriers.
  Assumes a single bus clock and a word-indexed register port.
*/
package uart_regs_pkg;

  // ==========================================================================
  // Register indices (one bus word each)
  localparam logic [2:0] IDX_RX_HOLDING   = 3'h0;
  localparam logic [2:0] IDX_TX_HOLDING   = 3'h1;
  localparam logic [2:0] IDX_LINE_STATUS  = 3'h2;
  localparam logic [2:0] IDX_IRQ_CONTROL  = 3'h3;
  localparam logic [2:0] IDX_BAUD_DIVISOR = 3'h4;
  localparam logic [2:0] IDX_PACKET_END   = 3'h5;

  // ==========================================================================
  // Status bit positions (control enables sit at the same positions)
  localparam int BIT_PARITY   = 0;
  localparam int BIT_STOP     = 1;
  localparam int BIT_BREAK    = 2;
  localparam int BIT_RX_OVR   = 3;
  localparam int BIT_TX_OVR   = 4;
  localparam int BIT_TX_EMPTY = 5;
  localparam int BIT_TX_READY = 6;
  localparam int BIT_RX_READY = 7;
  localparam int BIT_FAULT    = 8;
  localparam int BIT_TX_BREAK = 9;
  localparam int BIT_CTS_CHG  = 10;
  localparam int BIT_CTS      = 11;
  localparam int BIT_EOP      = 12;

  // ==========================================================================
  // Widths and reset values
  localparam int          REG_W          = 16;
  localparam logic [15:0] CONTROL_RST    = 16'h0000;
  localparam logic [15:0] DIVISOR_RST    = 16'h0364;
  localparam logic [15:0] PACKET_END_RST = 16'h0000;
  localparam logic [15:0] UNDEF_READ     = 16'h0000;
  localparam logic [12:0] CONTROL_MASK   = 13'h1_FFF;
  localparam int          FIFO_DEPTH     = 16;

  // ==========================================================================
  // Carriers
  typedef struct packed
  {
    logic        rd;
    logic        wr;
    logic [2:0]  addr;
    logic [15:0] wdata;
  } bus_req_t;

  typedef struct packed
  {
    logic        parity_bad;
    logic        stop_bad;
    logic [15:0] data;
  } rx_char_t;

endpackage

// ---- rtl/char_fifo.sv ----
/*
  Parameterised synchronous FIFO with valid/ready on both sides.
  Assumes one clock and a synchronous active-high reset.
*/
module char_fifo
  import uart_regs_pkg::*;
#(
  parameter int WIDTH = 18,
  parameter int DEPTH = 16
)
(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_r;
  logic [AW-1:0]    rd_ptr_r;
  logic [AW:0]      count_r;
  logic             push;
  logic             pop;

  assign in_ready  = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data  = mem[rd_ptr_r];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk)
  begin
    if (push)
    begin
      mem[wr_ptr_r] <= in_data;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r  <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr_r <= (wr_ptr_r == AW'(DEPTH - 1)) ? '0 : wr_ptr_r + 1'b1;
      end
      if (pop)
      begin
        rd_ptr_r <= (rd_ptr_r == AW'(DEPTH - 1)) ? '0 : rd_ptr_r + 1'b1;
      end
      count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

endmodule

// ---- verification/tx_shifter_model.sv ----
/*
  Behavioural transmit shifter facing the register block.
  Assumes one clock; stall and len come from the bench.
*/
module tx_shifter_model
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Load handshake
  input  wire logic        load,
  input  wire logic [15:0] char_in,
  output logic             busy,
  output logic             take,
  // Bench controls
  input  wire logic        stall,
  input  wire logic [7:0]  len,
  output logic      [15:0] sent
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] cnt_r;
  assign busy = cnt_r != 8'h00;
  // ==========
  // Shifting
  // Take is a single pulse so one waiting character is taken once
  always @(posedge clk)
  begin
    if (rst)
    begin
      take <= 1'b0;
      cnt_r <= 8'h00;
      sent <= 16'h0000;
    end
    else
    begin
      take <= !take && !busy && load && !stall;
      if (take)
      begin
        cnt_r <= len;
        sent <= char_in;
      end
      else if (busy)
        cnt_r <= cnt_r - 8'h01;
    end
  end
endmodule

// ---- verification/uart_regs_assertions.sv ----
/*
  Port checks for the serial port register block.
  Assumes it is bound to uart_regs and sees only its ports.
*/
module uart_regs_assertions
  import uart_regs_pkg::*;
#(
  parameter int DATA_W = 8
)
(
  // Clock and reset
  input wire logic        SYS_CLK,
  input wire logic        RST,
  // Register port
  input wire logic        CHIP_SELECT,
  input wire logic        READ_EN,
  input wire logic        WRITE_EN,
  input wire logic [2:0]  ADDRESS,
  input wire logic [15:0] WRITE_DATA,
  input wire logic [15:0] READ_DATA,
  input wire logic        IRQ,
  input wire logic        RTS_N,
  // Transmit shifter
  input wire logic        TX_TAKE,
  input wire logic        TX_LOAD,
  input wire logic [15:0] TX_CHAR,
  input wire logic [15:0] BAUD_DIVISOR
);
  timeunit 1ns;
  timeprecision 1ps;
  logic rd_c;
  logic wr_c;
  assign rd_c = CHIP_SELECT && READ_EN;
  assign wr_c = CHIP_SELECT && WRITE_EN;
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  // ==========
  // Checks
  chk_reset_outs_idle:
    assert property ($fell(RST) |-> !IRQ && !TX_LOAD && RTS_N)
    else $error("outputs not idle after reset");
  chk_tx_load_delay:
    assert property (wr_c && ADDRESS == IDX_TX_HOLDING |-> ##2 TX_LOAD)
    else $error("no load two cycles after transmit write");
  chk_tx_load_holds:
    assert property (TX_LOAD && !TX_TAKE |=> TX_LOAD)
    else $error("load dropped before take");
  chk_tx_char_stable:
    assert property (TX_LOAD && !TX_TAKE
      && !(wr_c && ADDRESS == IDX_TX_HOLDING) |=> $stable(TX_CHAR))
    else $error("held character changed");
  chk_rx_high_zero:
    assert property (rd_c && ADDRESS == IDX_RX_HOLDING
      |=> (READ_DATA >> DATA_W) == 16'h0000)
    else $error("bits above data width not zero");
  chk_unmapped_read:
    assert property (rd_c && ADDRESS > IDX_PACKET_END
      |=> READ_DATA == UNDEF_READ)
    else $error("unmapped read not zero");
  chk_fault_summary:
    assert property (rd_c && ADDRESS == IDX_LINE_STATUS
      |=> READ_DATA[BIT_FAULT] == (|READ_DATA[4:0]))
    else $error("fault summary wrong");
  chk_divisor_load:
    assert property (wr_c && ADDRESS == IDX_BAUD_DIVISOR
      |=> BAUD_DIVISOR == $past(WRITE_DATA))
    else $error("divisor not written");
endmodule

bind uart_regs uart_regs_assertions #(.DATA_W(DATA_W)) uart_regs_assertions_i
(
  .SYS_CLK, .RST, .CHIP_SELECT, .READ_EN, .WRITE_EN, .ADDRESS,
  .WRITE_DATA, .READ_DATA, .IRQ, .RTS_N, .TX_TAKE, .TX_LOAD,
  .TX_CHAR, .BAUD_DIVISOR
);

// ---- verification/uart_regs_test.sv ----
/*
  Self-checking bench for the serial port register block.
  Assumes the transmit shifter model and the bound checker.
*/
module uart_regs_test
  import uart_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ==========
  // Signals
  logic        clk = 1'b0, rst = 1'b1, cs = 1'b0, re = 1'b0, we = 1'b0;
  logic        rxd = 1'b1, cts_n = 1'b1, rx_done = 1'b0, par_bad = 1'b0;
  logic        stop_bad = 1'b0, stall = 1'b0, irq, busy, take, load;
  logic        rts_n, brk, frdy;
  logic [2:0]  addr = 3'h0;
  logic [15:0] wd = 16'h0000, rx_char = 16'h0000, lfsr = 16'h5107;
  logic [15:0] rdata, tx_char, sent, c;
  int          num_errors = 0, check_count = 0;

  uart_regs uart_regs_i (
    .SYS_CLK(clk), .RST(rst), .CHIP_SELECT(cs), .READ_EN(re),
    .WRITE_EN(we), .ADDRESS(addr), .WRITE_DATA(wd),
    .READ_DATA(rdata), .IRQ(irq), .RXD(rxd), .CTS_N(cts_n),
    .RTS_N(rts_n), .TX_BREAK(brk), .RX_DONE(rx_done),
    .RX_CHAR(rx_char), .RX_PARITY_BAD(par_bad), .RX_STOP_BAD(stop_bad),
    .RX_FIFO_READY(frdy), .TX_BUSY(busy), .TX_TAKE(take),
    .TX_LOAD(load), .TX_CHAR(tx_char), .BAUD_DIVISOR());
  tx_shifter_model tx_shifter_model_i (
    .clk, .rst, .load, .char_in(tx_char), .busy, .take, .stall,
    .len(8'h14), .sent);

  initial
    forever #4 clk = ~clk;
  // ==========
  // Helpers
  // Idle transmitter adds ready and empty; faults add the summary bit
  function automatic logic [15:0] st(input logic [15:0] f);
    st = f | 16'h0060 | {7'h00, |f[4:0], 8'h00};
  endfunction
  function automatic logic [15:0] nxt(input logic [15:0] x);
    nxt = {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e)
    begin
      num_errors++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    cs <= 1'b1;
    we <= 1'b1;
    addr <= a;
    wd <= d;
    @(posedge clk);
    cs <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rc(input logic [2:0] a, input logic [15:0] e);
    @(posedge clk);
    cs <= 1'b1;
    re <= 1'b1;
    addr <= a;
    @(posedge clk);
    cs <= 1'b0;
    re <= 1'b0;
    #1 chk(rdata, e);
  endtask
  // Holding register settles two edges and interrupt three edges after the strobe is driven
  task automatic rx(input logic [15:0] d, input logic [1:0] f);
    @(posedge clk);
    rx_done <= 1'b1;
    rx_char <= d;
    {stop_bad, par_bad} <= f;
    @(posedge clk);
    rx_done <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic conclude;
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========
  // Tests
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    rc(3'h3, CONTROL_RST);
    chk({13'h0000, frdy, rts_n, brk}, 16'h0006);
    rc(3'h4, DIVISOR_RST);
    rc(3'h5, PACKET_END_RST);
    rc(3'h2, st(16'h0000));
    rc(3'h6, UNDEF_READ);
    $display("reset test done");
    for (int i = 0; i < 4; i++)
    begin
      lfsr = nxt(lfsr);
      c = lfsr | 16'h0001;
      rx(c, 2'b00);
      wr(3'h0, ~c);
      rc(3'h2, st(16'h0080));
      rc(3'h0, c & 16'h00ff);
      rc(3'h2, st(16'h0000));
    end
    rx(16'h00a5, 2'b00);
    rx(16'h005a, 2'b00);
    rc(3'h2, st(16'h0088));
    rc(3'h2, st(16'h0088));
    rc(3'h0, 16'h005a);
    wr(3'h2, 16'h0000);
    rc(3'h2, st(16'h0000));
    for (int i = 0; i < 2; i++)
    begin
      rx(16'h0033, 2'(1 << i));
      rc(3'h2, st(16'h0080 | 16'(1 << i)));
      wr(3'h2, 16'h0000);
      rc(3'h0, 16'h0033);
    end
    $display("receive test done");
    wr(3'h3, 16'h0080);
    rc(3'h3, 16'h0080);
    rx(16'h0011, 2'b00);
    chk({15'h0000, irq}, 16'h0001);
    rc(3'h0, 16'h0011);
    repeat (2) @(posedge clk);
    #1 chk({15'h0000, irq}, 16'h0000);
    wr(3'h3, 16'h0000);
    $display("interrupt test done");
    stall <= 1'b1;
    wr(3'h1, 16'h0155);
    repeat (2) @(posedge clk);
    rc(3'h2, 16'h0000);
    wr(3'h1, 16'h01c3);
    repeat (2) @(posedge clk);
    rc(3'h2, 16'h0110);
    chk(tx_char, 16'h00c3);
    @(posedge clk) stall <= 1'b0;
    for (int n = 0; n < 50 && load; n++)
      @(posedge clk) #1;
    rc(3'h2, 16'h0150);
    chk(sent, 16'h00c3);
    repeat (30) @(posedge clk);
    rc(3'h2, 16'h0170);
    wr(3'h2, 16'h0000);
    $display("transmit test done");
    cts_n <= 1'b0;
    repeat (8) @(posedge clk);
    rc(3'h2, st(16'h0c00));
    // Break and request-to-send bits are not enables: no interrupt
    wr(3'h3, 16'h0a00);
    rc(3'h3, 16'h0a00);
    chk({14'h0000, rts_n, brk}, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(3'h3, 16'h0000);
    wr(3'h2, 16'h0000);
    cts_n <= 1'b1;
    repeat (8) @(posedge clk);
    rc(3'h2, st(16'h0400));
    wr(3'h2, 16'h0000);
    $display("flow test done");
    // Divisor 3 makes a character time of 44 cycles
    wr(3'h4, 16'h0003);
    rxd <= 1'b0;
    repeat (60) @(posedge clk);
    rxd <= 1'b1;
    repeat (8) @(posedge clk);
    rc(3'h2, st(16'h0004));
    wr(3'h2, 16'h0000);
    $display("break test done");
    wr(3'h5, 16'h0042);
    rx(16'h0042, 2'b00);
    rc(3'h2, st(16'h1080));
    $display("packet test done");
    conclude();
  end
  initial
  begin
    repeat (5000) @(posedge clk);
    num_errors++;
    conclude();
  end
endmodule
